// file: hdl/smc_pkg.sv
`default_nettype none
package smc_pkg;
  // Register byte offsets
  localparam logic [7:0] SMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMC_IDLE_OFS = 8'h04;
  localparam logic [7:0] SMC_PERIOD_OFS = 8'h08;
  localparam logic [7:0] SMC_STATUS_OFS = 8'h0c;
  // Control field positions
  localparam int SMC_MODE_LSB = 0;
  localparam int SMC_MODE_MSB = 2;
  localparam int SMC_CE_BIT = 3;
  localparam int SMC_CTSCFG_BIT = 4;
  // Status field positions
  localparam int SMC_ST_STATE_LSB = 0;
  localparam int SMC_ST_ASLEEP_BIT = 3;
  localparam int SMC_ST_HELD_BIT = 4;
  localparam int SMC_ST_PINWOKE_BIT = 5;
  // Reset values
  localparam logic [2:0] SMC_MODE_RST = 3'h0;
  localparam logic [15:0] SMC_IDLE_RST = 16'h0064;
  localparam logic [15:0] SMC_PERIOD_RST = 16'h0064;
  // Mode codes
  localparam logic [2:0] SMC_MODE_OFF = 3'h0;
  localparam logic [2:0] SMC_MODE_HIB = 3'h1;
  localparam logic [2:0] SMC_MODE_DOZE = 3'h2;
  localparam logic [2:0] SMC_MODE_CYC = 3'h4;
  localparam logic [2:0] SMC_MODE_CYCPIN = 3'h5;
  localparam logic [2:0] SMC_MODE_COORD = 3'h6;
  // Timing
  localparam int SMC_CLK_PERIOD_NS = 50;
  localparam int SMC_TICK_TIME_NS = 1000000;
  localparam int SMC_TICK_CYCLES = SMC_TICK_TIME_NS / SMC_CLK_PERIOD_NS;
  localparam int SMC_HIB_WAKE_NS = 10200000;
  localparam int SMC_HIB_WAKE_CYCLES = SMC_HIB_WAKE_NS / SMC_CLK_PERIOD_NS;
  localparam int SMC_DOZE_WAKE_NS = 2600000;
  localparam int SMC_DOZE_WAKE_CYCLES = SMC_DOZE_WAKE_NS / SMC_CLK_PERIOD_NS;
  localparam int SMC_LAT_W = 20;
  typedef enum logic [2:0] {S_AWAKE, S_DRAIN, S_SLEEP, S_WAKING, S_POLL} smc_state_t;
endpackage : smc_pkg
`default_nettype wire

// file: hdl/smc_timer.sv
`default_nettype none
module smc_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic run,
  input wire logic tick,
  output logic expired
);
  logic [W-1:0] count;
  logic armed;

  // Reloaded from its setting, counts down on the timebase tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      armed <= 1'b0;
    end else if (load) begin
      count <= load_value;
      armed <= 1'b1;
    end else if (run && tick && count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign expired = armed && (count == '0);
endmodule : smc_timer
`default_nettype wire

// file: hdl/smc_ctrl.sv
// Contract
// - Pin request sleeps only in modes 1, 2 or 5 with request high.
// - Idle timer expiry sleeps the device; idle timer works only in modes 4, 5.
// - Mode 0 disables sleep; device stays awake and responsive.
// - Mode 1 finishes pending work, passes idle, sleeps, ignores activity.
// - Pin modes 1 and 2 are level sensitive: high sleeps, low wakes.
// - After pin release the device wakes and drives CTS low when ready.
// - Wake latency about 10.2 ms hibernate, 2.6 ms doze and cyclic.
// - Mode 4 wakes once per sleep period and sends a poll request.
// - Empty poll sleeps again; data keeps device awake until idle expiry.
// - If configured, cyclic remote drives CTS low on every wake.
// - Mode 5 also wakes on falling request edge, then CTS low.
// - Mode 5 activity restarts the idle timer.
// - After pin wake in mode 5 the pin is ignored until sleep.
// - Coordinator (mode 6 or enable bit) stays awake, buffers addressed messages.
// - On a matching poll the coordinator sends the buffered message.
// - Coordinator holds at most one indirect message.
// - Buffered message kept 2.5 sleep periods from acceptance.
//
// Decided for this implementation: the register offsets and the strobed register port.
`default_nettype none
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int TICK_CYCLES = smc_pkg::SMC_TICK_CYCLES,
  parameter int HIB_WAKE_CYCLES = smc_pkg::SMC_HIB_WAKE_CYCLES,
  parameter int DOZE_WAKE_CYCLES = smc_pkg::SMC_DOZE_WAKE_CYCLES,
  parameter int DW = 8
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SLEEP_REQUEST_PIN,
  output logic CTS_N,
  output logic ASLEEP,
  input wire logic TXRX_BUSY,
  input wire logic ACTIVITY,
  output logic POLL_REQ,
  input wire logic POLL_DATA_RX,
  input wire logic POLL_EMPTY,
  input wire logic MSG_VALID,
  input wire logic [63:0] MSG_ADDR,
  input wire logic [DW-1:0] MSG_DATA,
  output logic MSG_READY,
  input wire logic POLL_RX,
  input wire logic [63:0] POLL_SRC,
  output logic MSG_TX_VALID,
  output logic [63:0] MSG_TX_ADDR,
  output logic [DW-1:0] MSG_TX_DATA
);
  import smc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0] sleep_mode_select;
  logic coordinator_role_enable;
  logic cts_on_wake;
  logic [15:0] idle_time_before_sleep;
  logic [15:0] cyclic_sleep_period;
  smc_state_t state;
  smc_state_t next_state;
  logic held;
  logic pin_woke;
  logic cyclic_wake;

  wire sel_ctrl = (ADDR == SMC_CTRL_OFS);
  wire sel_idle = (ADDR == SMC_IDLE_OFS);
  wire sel_period = (ADDR == SMC_PERIOD_OFS);
  wire sel_status = (ADDR == SMC_STATUS_OFS);
  wire [31:0] ctrl_word = {27'h0, cts_on_wake, coordinator_role_enable, sleep_mode_select};
  wire [31:0] status_word = {26'h0, pin_woke, held, ASLEEP, state};
  wire [31:0] read_mux = sel_ctrl ? ctrl_word :
                         sel_idle ? {16'h0, idle_time_before_sleep} :
                         sel_period ? {16'h0, cyclic_sleep_period} :
                         sel_status ? status_word : 32'h0;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sleep_mode_select <= SMC_MODE_RST;
      coordinator_role_enable <= 1'b0;
      cts_on_wake <= 1'b0;
      idle_time_before_sleep <= SMC_IDLE_RST;
      cyclic_sleep_period <= SMC_PERIOD_RST;
    end else if (WR) begin
      if (sel_ctrl) begin
        sleep_mode_select <= WDATA[SMC_MODE_MSB:SMC_MODE_LSB];
        coordinator_role_enable <= WDATA[SMC_CE_BIT];
        cts_on_wake <= WDATA[SMC_CTSCFG_BIT];
      end else if (sel_idle) begin
        idle_time_before_sleep <= WDATA[15:0];
      end else if (sel_period) begin
        cyclic_sleep_period <= WDATA[15:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? read_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  logic req_meta;
  logic req_s;
  logic req_prev;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      req_meta <= 1'b0;
      req_s <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      req_meta <= SLEEP_REQUEST_PIN;
      req_s <= req_meta;
      req_prev <= req_s;
    end
  end
  wire req_fall = req_prev && !req_s;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and timers
  logic [31:0] tick_cnt;
  wire tick = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  wire coord = (sleep_mode_select == SMC_MODE_COORD) || coordinator_role_enable;
  wire lvl_mode = (sleep_mode_select == SMC_MODE_HIB) || (sleep_mode_select == SMC_MODE_DOZE);
  wire cyc_mode = (sleep_mode_select == SMC_MODE_CYC) ||
                  (sleep_mode_select == SMC_MODE_CYCPIN);
  wire pin5 = (sleep_mode_select == SMC_MODE_CYCPIN);
  wire idle_raw;
  wire per_raw;
  wire ret_raw;

  smc_timer #(.W(16)) u_idle (
    .clk(REF_CLK),
    .rst(RST),
    .load(state != S_AWAKE || ACTIVITY || TXRX_BUSY || !cyc_mode),
    .load_value(idle_time_before_sleep),
    .run(state == S_AWAKE),
    .tick(tick),
    .expired(idle_raw)
  );
  wire idle_exp = cyc_mode && idle_raw && (state == S_AWAKE);

  smc_timer #(.W(16)) u_period (
    .clk(REF_CLK),
    .rst(RST),
    .load(state != S_SLEEP),
    .load_value(cyclic_sleep_period),
    .run(state == S_SLEEP),
    .tick(tick),
    .expired(per_raw)
  );

  wire [18:0] five_p = {1'b0, cyclic_sleep_period, 2'b00} + {3'b000, cyclic_sleep_period};
  wire accept = MSG_VALID && MSG_READY;
  smc_timer #(.W(18)) u_retain (
    .clk(REF_CLK),
    .rst(RST),
    .load(accept),
    .load_value(five_p[18:1]),
    .run(held),
    .tick(tick),
    .expired(ret_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine
  logic [SMC_LAT_W-1:0] lat_cnt;
  wire [SMC_LAT_W-1:0] lat_target = (sleep_mode_select == SMC_MODE_HIB) ?
      SMC_LAT_W'(HIB_WAKE_CYCLES) : SMC_LAT_W'(DOZE_WAKE_CYCLES);
  wire lat_done = (lat_cnt >= lat_target - 1'b1);
  wire pin_sleep_req = req_s && (lvl_mode || (pin5 && !pin_woke));
  wire wake_cond = (lvl_mode && !req_s) || (cyc_mode && per_raw) || (pin5 && req_fall) ||
                   !(lvl_mode || cyc_mode) || coord;

  always_comb begin
    next_state = state;
    case (state)
      S_AWAKE: begin
        if (!coord && (pin_sleep_req || idle_exp)) begin
          next_state = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (coord || (lvl_mode && !req_s) || !(lvl_mode || cyc_mode)) begin
          next_state = S_AWAKE;
        end else if (!TXRX_BUSY) begin
          next_state = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (wake_cond) begin
          next_state = S_WAKING;
        end
      end
      S_WAKING: begin
        if (lat_done) begin
          next_state = cyclic_wake ? S_POLL : S_AWAKE;
        end
      end
      S_POLL: begin
        if (POLL_DATA_RX) begin
          next_state = S_AWAKE;
        end else if (POLL_EMPTY) begin
          next_state = S_SLEEP;
        end
      end
      default: next_state = S_AWAKE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= S_AWAKE;
      lat_cnt <= '0;
      cyclic_wake <= 1'b0;
      pin_woke <= 1'b0;
      POLL_REQ <= 1'b0;
    end else begin
      state <= next_state;
      lat_cnt <= (state == S_WAKING) ? lat_cnt + 1'b1 : '0;
      if (state == S_SLEEP && wake_cond) begin
        cyclic_wake <= cyc_mode && per_raw && !(pin5 && req_fall);
        pin_woke <= pin5 && req_fall;
      end else if (next_state == S_SLEEP || !pin5) begin
        pin_woke <= 1'b0;
      end
      POLL_REQ <= (state == S_WAKING) && lat_done && cyclic_wake;
    end
  end

  assign ASLEEP = (state == S_SLEEP);
  assign CTS_N = !((state == S_AWAKE) || (state == S_POLL && cts_on_wake));

  ////////////////////////////////////////////////////////////////////////////
  // Coordinator indirect message slot
  wire poll_hit = held && POLL_RX && (POLL_SRC == MSG_TX_ADDR);
  logic [63:0] held_addr;
  logic [DW-1:0] held_data;
  assign MSG_READY = coord && !held;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      held <= 1'b0;
      held_addr <= 64'h0;
      held_data <= '0;
      MSG_TX_VALID <= 1'b0;
      MSG_TX_DATA <= '0;
    end else begin
      MSG_TX_VALID <= poll_hit;
      if (poll_hit) begin
        MSG_TX_DATA <= held_data;
      end
      if (accept) begin
        held <= 1'b1;
        held_addr <= MSG_ADDR;
        held_data <= MSG_DATA;
      end else if (poll_hit || ret_raw || !coord) begin
        held <= 1'b0;
      end
    end
  end
  assign MSG_TX_ADDR = held_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence pin_release_s;
    state == S_SLEEP && lvl_mode && !req_s && !coord;
  endsequence
  sequence woke_s;
    state == S_WAKING ##1 state == S_AWAKE;
  endsequence

  mode_off_awake_a: assert property (
    state == S_AWAKE && sleep_mode_select == SMC_MODE_OFF |=> state == S_AWAKE)
    else $error("mode off left awake state");
  pin_sleep_entry_a: assert property (
    state == S_AWAKE && lvl_mode && req_s && !coord |=> state == S_DRAIN)
    else $error("pin request did not start sleep");
  drain_hold_a: assert property (
    state == S_DRAIN && TXRX_BUSY && lvl_mode && req_s && !coord |=> state == S_DRAIN)
    else $error("slept with work pending");
  level_wake_a: assert property (
    pin_release_s |=> state == S_WAKING)
    else $error("level release did not wake");
  cts_ready_a: assert property (
    woke_s |-> !CTS_N && $past(CTS_N))
    else $error("CTS not low after wake");
  wake_latency_a: assert property (
    state == S_WAKING && !lat_done |=> state == S_WAKING)
    else $error("wake latency cut short");
  poll_emit_a: assert property (
    state == S_WAKING && lat_done && cyclic_wake |=> POLL_REQ && state == S_POLL)
    else $error("no poll on cyclic wake");
  empty_resleep_a: assert property (
    state == S_POLL && !POLL_DATA_RX && POLL_EMPTY |=> state == S_SLEEP)
    else $error("empty poll did not resleep");
  edge_wake_a: assert property (
    state == S_SLEEP && pin5 && req_fall && !coord |=> state == S_WAKING ##1 pin_woke)
    else $error("falling edge did not wake");
  pin_ignored_a: assert property (
    state == S_AWAKE && pin5 && pin_woke && !idle_exp && !coord |=> state == S_AWAKE)
    else $error("pin acted after pin wake");
  coord_awake_a: assert property (
    coord && state == S_AWAKE |=> state == S_AWAKE)
    else $error("coordinator left awake");
  single_slot_a: assert property (
    held && MSG_VALID |=> $stable(held_addr) && $stable(held_data))
    else $error("second message accepted");
  poll_deliver_a: assert property (
    poll_hit && !accept |=> MSG_TX_VALID && !held)
    else $error("matching poll not served");
endmodule : smc_ctrl
`default_nettype wire

// file: sim/smc_host_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module smc_host_model #(
  parameter int BYTE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic want_sleep,
  input wire logic cts_n,
  output logic sleep_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold;
  logic cts_d;
  logic cts_fell;
  assign cts_fell = cts_d && !cts_n;
  // Request stays low two byte times after the device says ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_pin <= 1'b0;
      hold <= 0;
      cts_d <= 1'b0;
    end else begin
      cts_d <= cts_n;
      if (cts_fell) begin
        hold <= 2 * BYTE_CYCLES;
      end else if (hold > 0) begin
        hold <= hold - 1;
      end
      sleep_pin <= want_sleep && (hold == 0) && !cts_fell;
    end
  end
endmodule : smc_host_model
`default_nettype wire

// file: sim/tb_sleep_mode_controller.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_sleep_mode_controller;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  localparam int HIB = 10;
  localparam int DOZE = 6;
  logic ref_clk;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic want_sleep = 1'b0;
  logic txrx_busy = 1'b0;
  logic activity = 1'b0;
  logic poll_data_rx = 1'b0;
  logic poll_empty = 1'b0;
  logic msg_valid = 1'b0;
  logic poll_rx = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [63:0] msg_addr = 64'h0;
  logic [63:0] poll_src = 64'h0;
  logic [7:0] msg_data = 8'h00;
  logic [15:0] lfsr = 16'h002f;
  logic [31:0] rdata;
  logic sleep_pin, cts_n, asleep, poll_req, msg_ready, msg_tx_valid;
  logic [63:0] msg_tx_addr;
  logic [7:0] msg_tx_data;
  logic [31:0] rd_q[$];
  logic [71:0] tx_q[$];
  logic [63:0] a;
  logic [7:0] d;
  logic [15:0] w;
  int err_total = 0;
  int checks_done = 0;
  int n;
  int lat;
  ////////////////////////////////////////////////////////////////////////////////
  smc_ctrl #(.TICK_CYCLES(4), .HIB_WAKE_CYCLES(HIB), .DOZE_WAKE_CYCLES(DOZE), .DW(8)) dut (
    .REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SLEEP_REQUEST_PIN(sleep_pin), .CTS_N(cts_n), .ASLEEP(asleep),
    .TXRX_BUSY(txrx_busy), .ACTIVITY(activity), .POLL_REQ(poll_req),
    .POLL_DATA_RX(poll_data_rx), .POLL_EMPTY(poll_empty), .MSG_VALID(msg_valid),
    .MSG_ADDR(msg_addr), .MSG_DATA(msg_data), .MSG_READY(msg_ready), .POLL_RX(poll_rx),
    .POLL_SRC(poll_src), .MSG_TX_VALID(msg_tx_valid), .MSG_TX_ADDR(msg_tx_addr),
    .MSG_TX_DATA(msg_tx_data)
  );
  smc_host_model #(.BYTE_CYCLES(8)) host (
    .clk(ref_clk), .rst(rst), .want_sleep(want_sleep), .cts_n(cts_n), .sleep_pin(sleep_pin)
  );
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic pick(input int s);
    return (s == 0) ? asleep : (s == 1) ? cts_n : (s == 2) ? poll_req : msg_ready;
  endfunction : pick
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wait_on(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_on
  task automatic wrreg(input logic [7:0] ad, input logic [31:0] dat);
    @(posedge ref_clk);
    addr <= ad;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wrreg
  task automatic rdreg(input logic [7:0] ad, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge ref_clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask : rdreg
  task automatic offer(input logic [63:0] ad, input logic [7:0] dat);
    @(posedge ref_clk);
    msg_valid <= 1'b1;
    msg_addr <= ad;
    msg_data <= dat;
    @(posedge ref_clk);
    msg_valid <= 1'b0;
    #1;
  endtask : offer
  task automatic poll(input logic [63:0] src);
    @(posedge ref_clk);
    poll_rx <= 1'b1;
    poll_src <= src;
    @(posedge ref_clk);
    poll_rx <= 1'b0;
    cyc(3);
  endtask : poll
  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against what shows up
  always @(posedge ref_clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      check(rdata, rd_q.size() ? rd_q.pop_front() : 'x);
    end
    if (msg_tx_valid === 1'b1) begin
      check({msg_tx_addr, msg_tx_data}, tx_q.size() ? tx_q.pop_front() : 'x);
    end
  end
  initial begin
    cyc(20000);
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    check({asleep, cts_n}, 2'b00);
    rdreg(SMC_CTRL_OFS, 32'h0);
    rdreg(SMC_IDLE_OFS, {16'h0, SMC_IDLE_RST});
    rdreg(SMC_PERIOD_OFS, {16'h0, SMC_PERIOD_RST});
    rdreg(8'h10, 32'h0);
    w = rnd();
    wrreg(SMC_PERIOD_OFS, {16'hffff, w});
    rdreg(SMC_PERIOD_OFS, {16'h0, w});
    wrreg(SMC_STATUS_OFS, 32'h3f);
    rdreg(SMC_STATUS_OFS, 32'h0);
    @(posedge ref_clk) want_sleep <= 1'b1;
    cyc(30);
    check({asleep, cts_n}, 2'b00);
    @(posedge ref_clk) want_sleep <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      lat = i ? DOZE : HIB;
      wrreg(SMC_CTRL_OFS, {29'h0, i ? SMC_MODE_DOZE : SMC_MODE_HIB});
      @(posedge ref_clk) txrx_busy <= 1'b1;
      @(posedge ref_clk) want_sleep <= 1'b1;
      cyc(25);
      check(asleep, 1'b0);
      @(posedge ref_clk) txrx_busy <= 1'b0;
      wait_on(0, 1'b1, 8);
      check({asleep, cts_n}, 2'b11);
      rdreg(SMC_STATUS_OFS, 32'h0000000a);
      @(posedge ref_clk) activity <= 1'b1;
      @(posedge ref_clk) activity <= 1'b0;
      cyc(3);
      check(asleep, 1'b1);
      @(posedge ref_clk) want_sleep <= 1'b0;
      wait_on(1, 1'b0, 40);
      check(n >= lat && n <= lat + 6, 1'b1);
      check(asleep, 1'b0);
    end
    wrreg(SMC_IDLE_OFS, 32'h2);
    wrreg(SMC_PERIOD_OFS, 32'h3);
    wrreg(SMC_CTRL_OFS, {27'h0, 1'b1, 1'b0, SMC_MODE_CYC});
    wait_on(0, 1'b1, 30);
    check(asleep, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wait_on(2, 1'b1, 40);
      check({poll_req, cts_n}, 2'b10);
      @(posedge ref_clk) {poll_data_rx, poll_empty} <= (i == 0) ? 2'b01 : 2'b10;
      @(posedge ref_clk) {poll_data_rx, poll_empty} <= 2'b00;
      if (i == 2) break;
      cyc(3);
      check(asleep, i == 0);
      wait_on(0, 1'b1, 30);
      check(asleep, 1'b1);
    end
    wrreg(SMC_CTRL_OFS, 32'h0);
    wrreg(SMC_PERIOD_OFS, 32'h200);
    wrreg(SMC_IDLE_OFS, 32'hc);
    wrreg(SMC_CTRL_OFS, {29'h0, SMC_MODE_CYCPIN});
    repeat (5) begin
      cyc(24);
      @(posedge ref_clk) activity <= 1'b1;
      @(posedge ref_clk) activity <= 1'b0;
    end
    check(asleep, 1'b0);
    wait_on(0, 1'b1, 70);
    check(asleep, 1'b1);
    @(posedge ref_clk) want_sleep <= 1'b1;
    cyc(6);
    @(posedge ref_clk) want_sleep <= 1'b0;
    wait_on(1, 1'b0, 20);
    check({asleep, cts_n}, 2'b00);
    @(posedge ref_clk) want_sleep <= 1'b1;
    cyc(30);
    check(asleep, 1'b0);
    wait_on(0, 1'b1, 60);
    check(asleep, 1'b1);
    @(posedge ref_clk) want_sleep <= 1'b0;
    wait_on(1, 1'b0, 20);
    wrreg(SMC_CTRL_OFS, {29'h0, SMC_MODE_COORD});
    @(posedge ref_clk) want_sleep <= 1'b1;
    a = {rnd(), rnd(), rnd(), rnd()};
    d = 8'(rnd());
    offer(a, d);
    check(msg_ready, 1'b0);
    rdreg(SMC_STATUS_OFS, 32'h00000010);
    offer(~a, ~d);
    poll(~a);
    tx_q.push_back({a, d});
    poll(a);
    check(msg_ready, 1'b1);
    check(asleep, 1'b0);
    wrreg(SMC_PERIOD_OFS, 32'h2);
    wrreg(SMC_CTRL_OFS, 32'h8);
    offer(a, d);
    cyc(14);
    check(msg_ready, 1'b0);
    wait_on(3, 1'b1, 20);
    check(msg_ready, 1'b1);
    poll(a);
    check(asleep, 1'b0);
    check(tx_q.size(), 0);
    check(rd_q.size(), 0);
    results();
  end
endmodule : tb_sleep_mode_controller
`default_nettype wire
